// ==== src/clk_sel_pkg.sv ====
// clk_sel_pkg: constants, codes and types shared by the cpu clock source selector.
// assumes a 200 MHz system clock; the free-running pll half period in cycles is derived from that rate.
package clk_sel_pkg;

    // system clock
    localparam int CLK_PERIOD_NS = 5;

    // free-running pll model: half period as a time, then as cycles (least time, rounded up)
    localparam int FREE_HALF_NS = 20;
    localparam int FREE_HALF_CYC_I = (FREE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] FREE_HALF_CYC = 4'(FREE_HALF_CYC_I);

    // oscillator supervisor overflow, in free-running pll cycles
    localparam logic [4:0] OSC_OVF_COUNT = 5'h10;

    // configuration codes on the clock config pins
    localparam logic [2:0] CFG_X4 = 3'h7;
    localparam logic [2:0] CFG_X3 = 3'h6;
    localparam logic [2:0] CFG_X2 = 3'h5;
    localparam logic [2:0] CFG_X5 = 3'h4;
    localparam logic [2:0] CFG_DIRECT = 3'h3;
    localparam logic [2:0] CFG_X1P5 = 3'h2;
    localparam logic [2:0] CFG_PRESCALE = 3'h1;
    localparam logic [2:0] CFG_X2P5 = 3'h0;
    localparam logic [2:0] CFG_RESET = 3'h7;

    // input period measurement width
    localparam int PER_W = 16;
    localparam int ACC_W = 17;
    localparam logic [PER_W-1:0] PER_MAX = 16'hffff;

    // clock source, gray along prescale / direct -> failsafe
    typedef enum logic [1:0] {
        SRC_PLL = 2'h0,
        SRC_DIRECT = 2'h1,
        SRC_FAILSAFE = 2'h3,
        SRC_PRESCALE = 2'h2
    } src_t;

    // cpu clock phases per input period (twice the factor)
    function automatic logic [3:0] phases_of(input logic [2:0] cfg);
        logic [3:0] p;
        p = 4'h8;
        unique case (cfg)
            CFG_X4: p = 4'h8;
            CFG_X3: p = 4'h6;
            CFG_X2: p = 4'h4;
            CFG_X5: p = 4'ha;
            CFG_X1P5: p = 4'h3;
            CFG_X2P5: p = 4'h5;
            CFG_DIRECT: p = 4'h2;
            CFG_PRESCALE: p = 4'h1;
        endcase
        return p;
    endfunction

    // input transitions between resynchronisations (factor, or whole periods for fractions)
    function automatic logic [2:0] resync_of(input logic [2:0] cfg);
        logic [2:0] r;
        r = 3'h4;
        unique case (cfg)
            CFG_X4: r = 3'h4;
            CFG_X3: r = 3'h3;
            CFG_X2: r = 3'h2;
            CFG_X5: r = 3'h5;
            CFG_X1P5: r = 3'h2;
            CFG_X2P5: r = 3'h2;
            CFG_DIRECT: r = 3'h2;
            CFG_PRESCALE: r = 3'h2;
        endcase
        return r;
    endfunction

    // source selected by a configuration code
    function automatic src_t src_of(input logic [2:0] cfg);
        src_t s;
        s = SRC_PLL;
        if (cfg == CFG_DIRECT)
        begin
            s = SRC_DIRECT;
        end
        else if (cfg == CFG_PRESCALE)
        begin
            s = SRC_PRESCALE;
        end
        return s;
    endfunction

endpackage

// ==== src/osc_sup_if.sv ====
// osc_sup_if: link between the clock selector and its oscillator supervisor.
// assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface osc_sup_if;
    logic run;
    logic in_edge;
    logic free_tick;
    logic overflow;

    modport ctrl (output run, output in_edge, output free_tick, input overflow);
    modport sup (input run, input in_edge, input free_tick, output overflow);
endinterface

// ==== src/osc_supervisor.sv ====
// osc_supervisor: counts free-running pll cycles, cleared by every input transition.
// assumes in_edge and free_tick are single-cycle pulses on i_clk.
`timescale 1ns/1ps
module osc_supervisor
    import clk_sel_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    osc_sup_if.sup bus
);

    typedef struct packed {
        logic [4:0] cnt;
        logic ovf;
    } sup_state_t;

    sup_state_t st_ff;
    sup_state_t nxt_st;

    // clear on transition wins over a tick in the same cycle
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.ovf = 1'b0;
        if (!bus.run || bus.in_edge)
        begin
            nxt_st.cnt = 5'h00; // see RL8
        end
        else if (bus.free_tick)
        begin
            if (st_ff.cnt == OSC_OVF_COUNT - 5'h01)
            begin
                nxt_st.cnt = 5'h00;
                nxt_st.ovf = 1'b1; // see RL8
            end
            else
            begin
                nxt_st.cnt = st_ff.cnt + 5'h01; // see RL8
            end
        end
        if (!i_rst_n)
        begin
            nxt_st = '0;
        end
    end

    // state register
    always_ff @(posedge i_clk)
    begin
        st_ff <= nxt_st;
    end

    assign bus.overflow = st_ff.ovf;

endmodule // osc_supervisor

// ==== src/cpu_clock_source_select.sv ====
// cpu_clock_source_select: picks and generates the cpu clock from the oscillator input.
// assumes i_clock_input_pin and i_clock_config_pins are asynchronous pins, and that
// i_osc_supervisor_disable comes from the system config register on i_clk.
// Function
// RL1: config pins sampled while reset is active choose the clock mechanism.
// RL2: codes map to x4,x3,x2,x5,direct,x1.5,divide-by-two,x2.5.
// RL3: code 001 toggles cpu clock once per input period.
// RL4: code 011 bypasses the pll and follows the input level.
// RL5: in direct drive two consecutive phases equal one input period.
// RL6: direct/prescale: pll runs for supervisor unless disable bit is set.
// RL7: both cpu clock edges are usable; phase is time between edges.
// RL8: supervisor counts pll cycles, cleared on input transitions, overflows at 16.
// RL9: overflow switches to free pll clock and flags irq until reset.
// RL10: supervisor enabled after reset; disable bit turns it off.
// RL11: pll modes resynchronise cpu clock every F-th input transition.
// RL12: sampled config code is held until the next reset.
`timescale 1ns/1ps
module cpu_clock_source_select
    import clk_sel_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clock_input_pin,
    input wire logic [2:0] i_clock_config_pins,
    input wire logic i_osc_supervisor_disable,
    output logic o_cpu_clk,
    output logic o_clock_phase_edge,
    output logic o_pll_enable,
    output logic o_clock_fail_irq,
    output logic [2:0] o_clock_config,
    output logic [1:0] o_clock_source
);

    typedef struct packed {
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        logic [2:0] cfg_s1;
        logic [2:0] cfg_s2;
        logic [2:0] cfg;
        src_t src;
        logic cpu_clk;
        logic phase_edge;
        logic free_clk;
        logic [3:0] free_cnt;
        logic [PER_W-1:0] per_cnt;
        logic [PER_W-1:0] per_meas;
        logic per_seen;
        logic [ACC_W-1:0] acc;
        logic [2:0] trans_cnt;
        logic fail;
    } sel_state_t;

    sel_state_t st_ff;
    sel_state_t nxt_st;
    osc_sup_if sup_bus ();

    logic pin_edge;
    logic pin_rise;
    logic free_wrap;
    logic sup_run;
    logic pll_on;
    logic [ACC_W-1:0] acc_sum;

    // input edges come only from the second sync stage onward
    assign pin_edge = st_ff.pin_s2 ^ st_ff.pin_prev;
    assign pin_rise = st_ff.pin_s2 & ~st_ff.pin_prev;
    assign free_wrap = (st_ff.free_cnt == FREE_HALF_CYC - 4'h1);
    // supervisor only guards the non-pll sources, and is on unless software disables it
    assign sup_run = ((st_ff.src == SRC_DIRECT) || (st_ff.src == SRC_PRESCALE))
                     && !i_osc_supervisor_disable; // see RL6 see RL10
    assign pll_on = (st_ff.src == SRC_PLL) || (st_ff.src == SRC_FAILSAFE) || sup_run; // see RL6
    assign acc_sum = st_ff.acc + ACC_W'(phases_of(st_ff.cfg));

    // supervisor hookup
    assign sup_bus.run = sup_run;
    assign sup_bus.in_edge = pin_edge;
    // one tick per free clock period, on its low-to-high wrap
    assign sup_bus.free_tick = pll_on && free_wrap && !st_ff.free_clk;

    osc_supervisor u_sup (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .bus(sup_bus.sup)
    );

    // next state of the whole selector
    always_comb
    begin
        nxt_st = st_ff;
        // two-stage synchronisers on the pins
        nxt_st.pin_s1 = i_clock_input_pin;
        nxt_st.pin_s2 = st_ff.pin_s1;
        nxt_st.pin_prev = st_ff.pin_s2;
        nxt_st.cfg_s1 = i_clock_config_pins;
        nxt_st.cfg_s2 = st_ff.cfg_s1;

        // free-running pll model, stopped when the pll is switched off
        if (!pll_on)
        begin
            nxt_st.free_cnt = 4'h0; // see RL6
            nxt_st.free_clk = 1'b0;
        end
        else if (free_wrap)
        begin
            nxt_st.free_cnt = 4'h0;
            nxt_st.free_clk = ~st_ff.free_clk;
        end
        else
        begin
            nxt_st.free_cnt = st_ff.free_cnt + 4'h1;
        end

        unique case (st_ff.src)
            SRC_DIRECT:
            begin
                nxt_st.cpu_clk = st_ff.pin_s2; // see RL4 see RL5
                // only a supervised source falls back; with the supervisor off a dead input stays dead
                if (sup_bus.overflow && sup_run)
                begin
                    nxt_st.src = SRC_FAILSAFE; // see RL9
                    nxt_st.fail = 1'b1;
                end
            end
            SRC_PRESCALE:
            begin
                // rising edges only, so each cpu phase lasts one whole input period
                if (pin_rise)
                begin
                    nxt_st.cpu_clk = ~st_ff.cpu_clk; // see RL3
                end
                if (sup_bus.overflow && sup_run)
                begin
                    nxt_st.src = SRC_FAILSAFE; // see RL9
                    nxt_st.fail = 1'b1;
                end
            end
            SRC_FAILSAFE:
            begin
                // no way back to the input without a reset, even if it recovers
                nxt_st.cpu_clk = st_ff.free_clk; // see RL9
            end
            SRC_PLL:
            begin
                // measure the input period in system cycles, saturating
                // the first rise after reset only starts the count: the span before it is no whole period
                if (pin_rise)
                begin
                    if (st_ff.per_seen)
                    begin
                        nxt_st.per_meas = (st_ff.per_cnt == PER_MAX) ? PER_MAX : st_ff.per_cnt + 16'h0001;
                    end
                    nxt_st.per_seen = 1'b1;
                    nxt_st.per_cnt = 16'h0000;
                end
                else if (st_ff.per_cnt != PER_MAX)
                begin
                    nxt_st.per_cnt = st_ff.per_cnt + 16'h0001;
                end
                // spread 2F phases evenly over one measured period
                if ((st_ff.per_meas != 16'h0000) && (acc_sum >= ACC_W'(st_ff.per_meas)))
                begin
                    nxt_st.acc = acc_sum - ACC_W'(st_ff.per_meas); // see RL2
                    nxt_st.cpu_clk = ~st_ff.cpu_clk;
                end
                else
                begin
                    // hold the accumulator empty until a period is known, so no burst of phases follows
                    nxt_st.acc = (st_ff.per_meas == '0) ? '0 : acc_sum;
                end
                // realign the phase generator to the input every F-th transition, every second one for x1.5 and x2.5
                if (pin_edge)
                begin
                    if (st_ff.trans_cnt == resync_of(st_ff.cfg) - 3'h1)
                    begin
                        nxt_st.trans_cnt = 3'h0;
                        nxt_st.acc = '0; // see RL11
                    end
                    else
                    begin
                        nxt_st.trans_cnt = st_ff.trans_cnt + 3'h1;
                    end
                end
            end
        endcase

        // a change of level is a usable cpu clock edge
        // taken from the next level so the flag stands in the same cycle as the new level
        nxt_st.phase_edge = nxt_st.cpu_clk ^ st_ff.cpu_clk; // see RL7

        // synchronous reset keeps loading the synchronised code; it is frozen at release
        if (!i_rst_n)
        begin
            nxt_st.cfg = st_ff.cfg_s2; // see RL1 see RL12
            nxt_st.src = src_of(st_ff.cfg_s2); // see RL2
            nxt_st.cpu_clk = 1'b0;
            nxt_st.phase_edge = 1'b0;
            nxt_st.free_clk = 1'b0;
            nxt_st.free_cnt = 4'h0;
            nxt_st.per_cnt = '0;
            nxt_st.per_meas = '0;
            nxt_st.per_seen = 1'b0;
            nxt_st.acc = '0;
            nxt_st.trans_cnt = 3'h0;
            nxt_st.fail = 1'b0;
        end
    end

    // state register
    always_ff @(posedge i_clk)
    begin
        st_ff <= nxt_st;
    end

    // outputs straight from the state register, all but the pll enable
    assign o_cpu_clk = st_ff.cpu_clk;
    assign o_clock_phase_edge = st_ff.phase_edge;
    // pll enable is decoded, not registered, so a change of the disable bit acts at once
    assign o_pll_enable = pll_on;
    assign o_clock_fail_irq = st_ff.fail; // see RL9
    assign o_clock_config = st_ff.cfg;
    assign o_clock_source = st_ff.src;

endmodule // cpu_clock_source_select

// ==== bench/osc_model.sv ====
// osc_model: behavioural oscillator on the clock input pin.
// assumes the bench sets high and low lengths in system cycles.
`timescale 1ns/1ps
module osc_model (
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic [7:0] i_hi,
    input wire logic [7:0] i_lo,
    output logic o_pin
);
    logic [7:0] cnt_ff;
    initial o_pin = 1'b0;
    // a stopped oscillator holds its level, as a dead crystal does
    always @(posedge i_clk)
    begin
        if (!i_run)
            cnt_ff <= 8'h01;
        else if (cnt_ff >= (o_pin ? i_hi : i_lo))
        begin
            cnt_ff <= 8'h01;
            o_pin <= !o_pin;
        end
        else
            cnt_ff <= cnt_ff + 8'h01;
    end
endmodule // osc_model

// ==== bench/cpu_clock_source_select_monitor.sv ====
// cpu_clock_source_select_monitor: port-level assertions for the clock selector.
// assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module cpu_clock_source_select_monitor (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clock_input_pin,
    input wire logic i_osc_supervisor_disable,
    input wire logic o_cpu_clk,
    input wire logic o_clock_phase_edge,
    input wire logic o_pll_enable,
    input wire logic o_clock_fail_irq,
    input wire logic [2:0] o_clock_config,
    input wire logic [1:0] o_clock_source
);
    logic pin_ff;
    logic [3:0] up_ff;
    logic [7:0] quiet_ff;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // cycles since release, and cycles without a pin transition while supervised
    always_ff @(posedge i_clk)
    begin
        pin_ff <= i_clock_input_pin;
        up_ff <= !i_rst_n ? 4'h0 : (up_ff == 4'hf ? up_ff : up_ff + 4'h1);
        if (!i_rst_n || i_osc_supervisor_disable || o_clock_source == 2'h0 || pin_ff != i_clock_input_pin)
            quiet_ff <= 8'h00;
        else if (quiet_ff != 8'hff)
            quiet_ff <= quiet_ff + 8'h01;
    end
    property p_cfg_hold;
        (up_ff != 4'h0) |-> $stable(o_clock_config);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config moved after reset");
    property p_src_map;
        (o_clock_source != 2'h3) |->
            o_clock_source == (o_clock_config == 3'h3 ? 2'h1 : o_clock_config == 3'h1 ? 2'h2 : 2'h0);
    endproperty
    a_src_map: assert property (p_src_map) else $error("source does not match config");
    property p_direct;
        (up_ff > 4'h4 && o_clock_source == 2'h1) |-> o_cpu_clk == $past(i_clock_input_pin, 3);
    endproperty
    a_direct: assert property (p_direct) else $error("direct clock not following pin");
    property p_prescale;
        (up_ff > 4'h4 && o_clock_source == 2'h2 && $rose(i_clock_input_pin)) |-> ##3 $changed(o_cpu_clk);
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler missed an input rise");
    property p_edge;
        (up_ff > 4'h1 && $changed(o_cpu_clk)) |-> ##[0:1] o_clock_phase_edge;
    endproperty
    a_edge: assert property (p_edge) else $error("cpu clock edge not flagged");
    property p_pll_en;
        o_pll_enable == !((o_clock_source == 2'h1 || o_clock_source == 2'h2) && i_osc_supervisor_disable);
    endproperty
    a_pll_en: assert property (p_pll_en) else $error("pll enable wrong");
    property p_irq_sticky;
        (up_ff > 4'h1 && $past(o_clock_fail_irq)) |-> (o_clock_fail_irq && o_clock_source == 2'h3);
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("fail state left before reset");
    property p_overflow;
        (quiet_ff == 8'ha0) |-> (o_clock_source == 2'h3 && o_clock_fail_irq);
    endproperty
    a_overflow: assert property (p_overflow) else $error("supervisor did not overflow");
endmodule // cpu_clock_source_select_monitor
bind cpu_clock_source_select cpu_clock_source_select_monitor mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_clock_input_pin(i_clock_input_pin), .i_osc_supervisor_disable(i_osc_supervisor_disable),
    .o_cpu_clk(o_cpu_clk), .o_clock_phase_edge(o_clock_phase_edge), .o_pll_enable(o_pll_enable),
    .o_clock_fail_irq(o_clock_fail_irq), .o_clock_config(o_clock_config), .o_clock_source(o_clock_source));

// ==== bench/test_cpu_clock_source_select.sv ====
// test_cpu_clock_source_select: self-checking bench for the cpu clock selector.
// assumes osc_model drives the clock input pin; inputs change 1 ns after each rising edge.
`timescale 1ns/1ps
module test_cpu_clock_source_select;
    logic i_clk, i_rst_n, run, dis, pin, o_cpu_clk, o_clock_phase_edge, o_pll_enable, o_clock_fail_irq;
    logic [2:0] cfg, o_clock_config;
    logic [1:0] o_clock_source;
    logic [7:0] hi, lo;
    int num_errors, samples_checked;
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    osc_model osc (.i_clk(i_clk), .i_run(run), .i_hi(hi), .i_lo(lo), .o_pin(pin));
    cpu_clock_source_select uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_clock_input_pin(pin),
        .i_clock_config_pins(cfg), .i_osc_supervisor_disable(dis), .o_cpu_clk(o_cpu_clk),
        .o_clock_phase_edge(o_clock_phase_edge), .o_pll_enable(o_pll_enable), .o_clock_fail_irq(o_clock_fail_irq),
        .o_clock_config(o_clock_config), .o_clock_source(o_clock_source));
    task tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task final_report;
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // oscillator stays still through reset so the code settles on quiet pins
    task start(input logic [2:0] c, input logic [7:0] h, input logic [7:0] l);
        run = 1'b0;
        hi = h;
        lo = l;
        cfg = c;
        i_rst_n = 1'b0;
        tick(20);
        i_rst_n = 1'b1;
        run = 1'b1;
    endtask
    // cycles until the cpu clock reaches level v, bounded
    task automatic wlvl(input logic v, output int n);
        n = 0;
        while (o_cpu_clk !== v)
        begin
            tick(1);
            n++;
            if (n > 500)
            begin
                num_errors++;
                final_report();
            end
        end
    endtask
    task automatic t_config;
        logic [1:0] s;
        for (int c = 0; c < 8; c++)
        begin
            start(3'(c), 8'h04, 8'h04);
            cfg = ~cfg;
            tick(10);
            s = (c == 3) ? 2'h1 : (c == 1) ? 2'h2 : 2'h0;
            chk("config", 8'(c), 8'(o_clock_config));
            chk("source", 8'(s), 8'(o_clock_source));
            chk("pll_enable", 8'h01, 8'(o_pll_enable));
        end
    endtask
    task automatic t_direct;
        int n, h, l;
        dis = 1'b1;
        start(3'h3, 8'h03, 8'h05);
        // a pin held high through reset would look like a rise at release; start from a real fall
        wlvl(1'b1, n);
        wlvl(1'b0, n);
        wlvl(1'b1, n);
        wlvl(1'b0, h);
        wlvl(1'b1, l);
        chk("direct_high", 8'h03, 8'(h));
        chk("direct_period", 8'h08, 8'(h + l));
        chk("pll_off", 8'h00, 8'(o_pll_enable));
        dis = 1'b0;
    endtask
    // prescaler, then loss of input with the supervisor left at its reset state
    task automatic t_prescale;
        int n, h, l;
        start(3'h1, 8'h02, 8'h04);
        wlvl(1'b0, n);
        wlvl(1'b1, n);
        wlvl(1'b0, h);
        wlvl(1'b1, l);
        chk("pre_high", 8'h06, 8'(h));
        chk("pre_low", 8'h06, 8'(l));
        run = 1'b0;
        tick(300);
        chk("pre_failsafe", 8'h03, 8'(o_clock_source));
    endtask
    task automatic t_pll;
        logic [2:0] codes [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
        int ph [6] = '{8, 6, 4, 10, 3, 5};
        int n;
        for (int i = 0; i < 6; i++)
        begin
            start(codes[i], 8'h3c, 8'h3c);
            tick(400);
            n = 0;
            repeat (480)
            begin
                tick(1);
                if (o_clock_phase_edge === 1'b1)
                    n++;
            end
            samples_checked++;
            if (n < 4 * ph[i] - 1 || n > 4 * ph[i] + 1)
            begin
                num_errors++;
                $display("mismatch pll_edges expected %0d seen %0d", 4 * ph[i], n);
            end
        end
    endtask
    task automatic t_fail;
        dis = 1'b1;
        start(3'h3, 8'h04, 8'h04);
        tick(40);
        run = 1'b0;
        tick(300);
        chk("irq_disabled", 8'h00, 8'(o_clock_fail_irq));
        dis = 1'b0;
        tick(300);
        chk("irq", 8'h01, 8'(o_clock_fail_irq));
        chk("failsafe", 8'h03, 8'(o_clock_source));
        chk("pll_on", 8'h01, 8'(o_pll_enable));
        run = 1'b1;
        tick(100);
        chk("no_return", 8'h03, 8'(o_clock_source));
        start(3'h3, 8'h04, 8'h04);
        tick(5);
        chk("irq_reset", 8'h00, 8'(o_clock_fail_irq));
        chk("src_reset", 8'h01, 8'(o_clock_source));
    endtask
    initial
    begin
        num_errors = 0;
        samples_checked = 0;
        i_rst_n = 1'b0;
        run = 1'b0;
        dis = 1'b0;
        cfg = 3'h7;
        hi = 8'h04;
        lo = 8'h04;
        t_config();
        t_direct();
        t_prescale();
        t_pll();
        t_fail();
        final_report();
    end
endmodule // test_cpu_clock_source_select
